// >>> pot_pkg.sv
package pot_pkg;

  // Register map and power-up values.
  localparam logic [7:0] WIPER_ADDR = 8'h00;
  localparam logic [7:0] ACR_ADDR = 8'h10;
  localparam logic [7:0] WIPER_RESET = 8'h80;
  localparam logic [7:0] ACR_RESET = 8'h40;
  localparam logic [7:0] ACR_MASK = 8'h40;
  localparam int SHUTDOWN_N_BIT_POS = 6;

  // Target identification: five fixed upper bits, then the two select pins.
  localparam logic [4:0] ID_PREFIX = 5'h14;

  // Synchroniser reset value, bits {supply, sel_lo, sel_hi, sda, scl}: bus idle high.
  localparam logic [4:0] PIN_IDLE = 5'h03;

  // Bit positions within a byte slot.
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] BIT_ACK = 4'h9;

  // Timing.
  localparam int CLK_NS = 10;
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int DIP_NS = 200;
  localparam int DIP_CYC = (DIP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 8;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ID,
    ST_REG,
    ST_WRITE,
    ST_READ
  } link_state_t;

endpackage

// >>> pot_wiper_register_bank.sv
`timescale 1ns/1ps
// Overview of operation
// - Wiper register is 8 bits; zero selects the tap nearest the low terminal.
// - All ones selects the tap nearest the high terminal.
// - Rising wiper value moves the tap monotonically from low toward high end.
// - Power-up loads the wiper register with mid-scale.
// - Register address 0 is the wiper, 10h the access control register.
// - Access control bit 6 is active-low shutdown; other bits read zero.
// - Shutdown opens the array and ties the wiper to the low terminal.
// - Shutdown bit reads one after power-up.
// - Entering shutdown keeps the stored wiper value.
// - Leaving shutdown reconnects the stored tap after a settling interval.
// - A long supply dip during shutdown resets the wiper to mid-scale.
// - Incoming bits are sampled on each rising bus clock edge.
// - Read data changes only after a falling bus clock edge.
// - The data line is only ever pulled low, never driven high.
// - Select pins form the two low address bits; only a match responds.
// - On a tap change the new tap connects before the old one drops.
// - The master may write and read back the wiper register.
// - Identification byte is 10100, select pins, then read/write bit.
// - Identification, address and write bytes are acknowledged; commit on ninth clock.
// - Acknowledge only after start plus valid identification, low in ninth clock.
module pot_wiper_register_bank
  import pot_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic addr_select_hi_i,
  input wire logic addr_select_lo_i,
  input wire logic supply_low_i,
  output logic [7:0] tap_o,
  output logic [7:0] tap_aux_o,
  output logic tap_aux_en_o,
  output logic wiper_conn_o,
  output logic array_open_o,
  output logic wiper_to_low_o
);

  logic link_bit;
  logic [4:0] pin_s1;
  logic [4:0] pin_s2;
  logic scl_prev;
  logic sda_prev;
  logic scl_q;
  logic sda_q;
  logic sel_hi_q;
  logic sel_lo_q;
  logic supply_low_q;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic bus_ev;
  link_state_t state;
  link_state_t ack_next;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] reg_ptr;
  logic [7:0] tx;
  logic master_nack;
  logic id_match;
  logic wr_stb;
  logic [7:0] rd_data;
  logic [7:0] wiper;
  logic [7:0] access_control;
  logic shutdown_n_bit_n;
  logic [CNT_W-1:0] settle_cnt;
  logic [CNT_W-1:0] dip_cnt;
  logic dip_trip;

  // The bus clock itself captures the data line; the bit stays put until the
  // next rising edge, so the system side reads it once its synced copy of the
  // clock has risen.
  always_ff @(posedge scl_i) begin
    link_bit <= sda_i;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      pin_s1 <= PIN_IDLE;
      pin_s2 <= PIN_IDLE;
    end else begin
      pin_s1 <= {supply_low_i, addr_select_lo_i, addr_select_hi_i, sda_i, scl_i};
      pin_s2 <= pin_s1;
    end
  end

  assign scl_q = pin_s2[0];
  assign sda_q = pin_s2[1];
  assign sel_hi_q = pin_s2[2];
  assign sel_lo_q = pin_s2[3];
  assign supply_low_q = pin_s2[4];

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= scl_q;
      sda_prev <= sda_q;
    end
  end

  assign scl_rise = scl_q & ~scl_prev;
  assign scl_fall = ~scl_q & scl_prev;
  assign start_ev = scl_q & scl_prev & sda_prev & ~sda_q;
  assign stop_ev = scl_q & scl_prev & ~sda_prev & sda_q;
  assign bus_ev = start_ev | stop_ev;

  assign id_match = (shreg[7:3] == ID_PREFIX) && (shreg[2:1] == {sel_hi_q, sel_lo_q});
  assign wr_stb = scl_rise && !bus_ev && (state == ST_WRITE) && (bit_cnt == BIT_LAST);

  always_comb begin
    case (reg_ptr)
      WIPER_ADDR: rd_data = wiper;
      ACR_ADDR: rd_data = access_control & ACR_MASK;
      default: rd_data = 8'h00;
    endcase
  end

  // Serial protocol engine. Bit count advances on rising edges, so the falling
  // edge that closes a start condition does not count as a data bit.
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      state <= ST_IDLE;
      ack_next <= ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      reg_ptr <= 8'h00;
      tx <= 8'h00;
      master_nack <= 1'b1;
      sda_oe_o <= 1'b0;
    end else if (start_ev) begin
      // A repeated start restarts at the identification byte.
      state <= ST_ID;
      bit_cnt <= 4'h0;
      sda_oe_o <= 1'b0;
    end else if (stop_ev) begin
      state <= ST_IDLE;
      sda_oe_o <= 1'b0;
    end else if (state != ST_IDLE) begin
      if (scl_rise) begin
        if (bit_cnt < BIT_LAST) begin
          shreg <= {shreg[6:0], link_bit};
          bit_cnt <= bit_cnt + 4'h1;
        end else if (bit_cnt == BIT_LAST) begin
          master_nack <= link_bit;
          bit_cnt <= BIT_ACK;
        end
      end
      if (scl_fall) begin
        if (bit_cnt == BIT_LAST) begin
          case (state)
            ST_ID: begin
              if (id_match) begin
                sda_oe_o <= 1'b1;
                ack_next <= shreg[0] ? ST_READ : ST_REG;
              end else begin
                state <= ST_IDLE;
              end
            end
            ST_REG: begin
              reg_ptr <= shreg;
              sda_oe_o <= 1'b1;
              ack_next <= ST_WRITE;
            end
            ST_WRITE: begin
              sda_oe_o <= 1'b1;
              ack_next <= ST_WRITE;
            end
            ST_READ: begin
              sda_oe_o <= 1'b0;
              ack_next <= ST_READ;
            end
            default: begin
              state <= ST_IDLE;
            end
          endcase
        end else if (bit_cnt == BIT_ACK) begin
          bit_cnt <= 4'h0;
          if (state == ST_READ && master_nack) begin
            state <= ST_IDLE;
            sda_oe_o <= 1'b0;
          end else if (ack_next == ST_READ) begin
            state <= ST_READ;
            tx <= {rd_data[6:0], 1'b0};
            sda_oe_o <= ~rd_data[7];
          end else begin
            state <= ack_next;
            sda_oe_o <= 1'b0;
          end
        end else if (state == ST_READ && bit_cnt != 4'h0) begin
          sda_oe_o <= ~tx[7];
          tx <= {tx[6:0], 1'b0};
        end
      end
    end
  end

  // The pin is open drain: its output value is always low.
  assign sda_o = 1'b0;

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      wiper <= WIPER_RESET;
    end else if (dip_trip) begin
      wiper <= WIPER_RESET;
    end else if (wr_stb && reg_ptr == WIPER_ADDR) begin
      wiper <= shreg;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      access_control <= ACR_RESET;
    end else if (wr_stb && reg_ptr == ACR_ADDR) begin
      access_control <= shreg & ACR_MASK;
    end
  end

  assign shutdown_n_bit_n = access_control[SHUTDOWN_N_BIT_POS];

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      array_open_o <= 1'b0;
      wiper_to_low_o <= 1'b0;
    end else begin
      array_open_o <= ~shutdown_n_bit_n;
      wiper_to_low_o <= ~shutdown_n_bit_n;
    end
  end

  // Wiper switches stay open in shutdown and reclose only after settling.
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      settle_cnt <= '0;
      wiper_conn_o <= 1'b1;
    end else if (!shutdown_n_bit_n) begin
      settle_cnt <= '0;
      wiper_conn_o <= 1'b0;
    end else if (!wiper_conn_o) begin
      if (settle_cnt == CNT_W'(SETTLE_CYC - 1)) begin
        wiper_conn_o <= 1'b1;
      end else begin
        settle_cnt <= settle_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      dip_cnt <= '0;
    end else if (!(supply_low_q && !shutdown_n_bit_n)) begin
      dip_cnt <= '0;
    end else if (dip_cnt != CNT_W'(DIP_CYC)) begin
      dip_cnt <= dip_cnt + 8'h01;
    end
  end

  assign dip_trip = (dip_cnt == CNT_W'(DIP_CYC));

  // Tap index equals the wiper value: 00h at the low end, FFh at the high end.
  // On a change the old tap is held on the auxiliary switch for one more cycle.
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      tap_o <= WIPER_RESET;
      tap_aux_o <= WIPER_RESET;
      tap_aux_en_o <= 1'b0;
    end else begin
      tap_aux_en_o <= (wiper != tap_o);
      if (wiper != tap_o) begin
        tap_o <= wiper;
        tap_aux_o <= tap_o;
      end
    end
  end

  a_power_up_values: assert property (@(posedge sys_clk_i)
    !reset_n_i |=> wiper == WIPER_RESET && access_control == ACR_RESET && shutdown_n_bit_n)
    else $error("power-up values wrong");

  a_acr_unused_zero: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (access_control & ~ACR_MASK) == 8'h00)
    else $error("unused control bits not zero");

  a_sda_low_only: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    sda_o == 1'b0)
    else $error("data line driven high");

  a_make_before_break: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    tap_o != $past(tap_o) |-> tap_aux_en_o && tap_aux_o == $past(tap_o) ##1 !tap_aux_en_o || tap_o != $past(tap_o))
    else $error("old tap dropped before new tap made");

  a_tap_follows_wiper: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $changed(wiper) |-> ##1 tap_o == $past(wiper))
    else $error("tap does not follow wiper");

  a_shutdown_keeps_wiper: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $fell(shutdown_n_bit_n) |-> $stable(wiper))
    else $error("wiper changed entering shutdown");

  a_shutdown_open: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !shutdown_n_bit_n |=> array_open_o && wiper_to_low_o && !wiper_conn_o)
    else $error("shutdown outputs wrong");

  a_settle_restore: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $rose(wiper_conn_o) |-> shutdown_n_bit_n && $past(settle_cnt) == CNT_W'(SETTLE_CYC - 1))
    else $error("wiper reconnected without settling");

  a_dip_mid_reset: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    dip_cnt == CNT_W'(DIP_CYC) |=> wiper == WIPER_RESET)
    else $error("wiper not reset after supply dip");

  a_write_commit: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    wr_stb && reg_ptr == WIPER_ADDR |=> wiper == $past(shreg) || $past(dip_trip))
    else $error("write data not committed");

  a_control_commit: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    wr_stb && reg_ptr == ACR_ADDR |=> access_control == ($past(shreg) & ACR_MASK))
    else $error("control write not committed through mask");

  a_undef_addr_inert: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    wr_stb && reg_ptr != WIPER_ADDR && reg_ptr != ACR_ADDR
      |=> $stable(access_control) && ($stable(wiper) || $past(dip_trip)))
    else $error("undefined address changed a register");

  a_id_mismatch_idle: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    scl_fall && !bus_ev && state == ST_ID && bit_cnt == BIT_LAST && !id_match
      |=> state == ST_IDLE && !sda_oe_o)
    else $error("foreign identification not ignored");

  a_ack_on_match: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    scl_fall && !bus_ev && state == ST_ID && bit_cnt == BIT_LAST |=> sda_oe_o == $past(id_match))
    else $error("identification acknowledge wrong");

  a_drive_on_fall: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $rose(sda_oe_o) |-> $past(scl_fall))
    else $error("data line changed outside clock low");

endmodule

// >>> pot_bus_master.sv
`timescale 1ns/1ps
// Two-wire bus master; the clock stands high between frames and moves only inside them.
module pot_bus_master #(
  parameter int Q = 6
) (
  input wire logic lclk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge lclk_i);
  endtask
  // Data moves while the clock is low and is sampled late in the high phase.
  task automatic one_bit(input logic b, output logic s);
    tk(Q);
    sda_low_o = ~b;
    tk(Q);
    scl_o = 1'b1;
    tk(2 * Q);
    s = sda_i;
    scl_o = 1'b0;
  endtask
  // Serves as first and as repeated start.
  task automatic start_c();
    tk(Q);
    sda_low_o = 1'b0;
    tk(Q);
    scl_o = 1'b1;
    tk(2 * Q);
    sda_low_o = 1'b1;
    tk(2 * Q);
    scl_o = 1'b0;
  endtask
  task automatic stop_c();
    tk(Q);
    sda_low_o = 1'b1;
    tk(Q);
    scl_o = 1'b1;
    tk(2 * Q);
    sda_low_o = 1'b0;
    tk(4 * Q);
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      one_bit(tx[i], s);
      rx[i] = s;
    end
    one_bit(1'b1, s);
    ack = ~s;
  endtask
  task automatic write_reg(input logic [6:0] dv, input logic [7:0] a, input logic [7:0] d,
                           output logic [2:0] acks);
    logic [7:0] rx;
    start_c();
    xfer({dv, 1'b0}, rx, acks[2]);
    xfer(a, rx, acks[1]);
    xfer(d, rx, acks[0]);
    stop_c();
  endtask
  task automatic read_reg(input logic [6:0] dv, input logic [7:0] a, output logic [7:0] d,
                          output logic [2:0] acks);
    logic n;
    start_c();
    xfer({dv, 1'b0}, d, acks[2]);
    xfer(a, d, acks[1]);
    start_c();
    xfer({dv, 1'b1}, d, acks[0]);
    xfer(8'hff, d, n);
    stop_c();
  endtask
  // Two data bytes in one read: the master acknowledges the first one.
  task automatic read_two(input logic [6:0] dv, input logic [7:0] a, output logic [7:0] d0,
                          output logic [7:0] d1, output logic [2:0] acks);
    logic s;
    logic n;
    start_c();
    xfer({dv, 1'b0}, d0, acks[2]);
    xfer(a, d0, acks[1]);
    start_c();
    xfer({dv, 1'b1}, d0, acks[0]);
    for (int i = 7; i >= 0; i--) begin
      one_bit(1'b1, s);
      d0[i] = s;
    end
    one_bit(1'b0, s);
    xfer(8'hff, d1, n);
    stop_c();
  endtask
endmodule

// >>> tb_pot_wiper_register_bank.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module tb_pot_wiper_register_bank
  import pot_pkg::*;
;
  logic sys_clk_i = 1'b0;
  logic lclk = 1'b0;
  logic reset_n_i = 1'b0;
  logic sel_hi = 1'b0;
  logic sel_lo = 1'b0;
  logic supply_low = 1'b0;
  logic scl, sda_low, sda, sda_o, sda_oe_o, prev_oe, tap_aux_en_o;
  logic wiper_conn_o, array_open_o, wiper_to_low_o;
  logic [7:0] tap_o, tap_aux_o, last_aux, prev, gap, last_gap;
  logic [7:0] ramp [6] = '{8'h00, 8'h01, 8'h7f, 8'h80, 8'hfe, 8'hff};
  logic [2:0] acks;
  logic [7:0] rd0, rd1;
  logic [6:0] dev;
  int bad_count = 0;
  int n_tests = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  initial begin
    #3.3;
    forever #6 lclk = ~lclk;
  end
  assign sda = (sda_low || sda_oe_o) ? 1'b0 : 1'b1;
  assign dev = {5'h14, sel_hi, sel_lo};
  pot_bus_master pot_bus_master_i (.lclk_i(lclk), .sda_i(sda), .scl_o(scl),
    .sda_low_o(sda_low));
  pot_wiper_register_bank pot_wiper_register_bank_i (.sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .addr_select_hi_i(sel_hi), .addr_select_lo_i(sel_lo), .supply_low_i(supply_low),
    .tap_o(tap_o), .tap_aux_o(tap_aux_o), .tap_aux_en_o(tap_aux_en_o),
    .wiper_conn_o(wiper_conn_o), .array_open_o(array_open_o),
    .wiper_to_low_o(wiper_to_low_o));
  always @(posedge sys_clk_i) begin
    prev_oe <= sda_oe_o;
    gap <= (wiper_conn_o === 1'b0 && array_open_o === 1'b0) ? gap + 8'h01 : 8'h00;
    if (wiper_conn_o === 1'b1 && gap != 8'h00) last_gap <= gap;
    if (tap_aux_en_o === 1'b1) last_aux <= tap_aux_o;
    if (reset_n_i && sda_oe_o !== prev_oe) `CHK(scl, 1'b0)
    if (sda_oe_o === 1'b1) `CHK(sda_o, 1'b0)
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    pot_bus_master_i.write_reg(dev, a, d, acks);
    `CHK(acks, 3'b111)
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    pot_bus_master_i.read_reg(dev, a, d, acks);
    `CHK(acks, 3'b111)
    `CHK(d, e)
  endtask
  task automatic wrap_up();
    if (bad_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    bad_count++;
    $display("ERROR %0t: run did not finish", $time);
    wrap_up();
  end
  initial begin
    repeat (16) @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    repeat (5) @(negedge sys_clk_i);
    `CHK(tap_o, 8'h80)
    `CHK({wiper_conn_o, array_open_o, wiper_to_low_o}, 3'b100)
    rd(8'h00, 8'h80);
    rd(8'h10, 8'h40);
    foreach (ramp[i]) begin
      prev = tap_o;
      wr(8'h00, ramp[i]);
      `CHK(tap_o, ramp[i])
      `CHK(last_aux, prev)
    end
    rd(8'h00, 8'hff);
    wr(8'h10, 8'hbf);
    rd(8'h10, 8'h00);
    `CHK({array_open_o, wiper_to_low_o, wiper_conn_o}, 3'b110)
    rd(8'h00, 8'hff);
    wr(8'h10, 8'h40);
    repeat (SETTLE_CYC + 5) @(negedge sys_clk_i);
    `CHK(last_gap inside {[SETTLE_CYC - 4:SETTLE_CYC + 1]}, 1'b1)
    `CHK({wiper_conn_o, array_open_o, tap_o}, {2'b10, 8'hff})
    wr(8'h10, 8'h00);
    @(negedge sys_clk_i);
    supply_low = 1'b1;
    repeat (DIP_CYC + 10) @(negedge sys_clk_i);
    supply_low = 1'b0;
    rd(8'h00, 8'h80);
    wr(8'h10, 8'h40);
    wr(8'h00, 8'h3c);
    wr(8'h05, 8'ha5);
    rd(8'h05, 8'h00);
    rd(8'h00, 8'h3c);
    rd(8'h10, 8'h40);
    @(negedge sys_clk_i);
    sel_hi = 1'b1;
    pot_bus_master_i.write_reg({5'h14, 2'b00}, 8'h00, 8'h11, acks);
    `CHK(acks, 3'b000)
    rd(8'h00, 8'h3c);
    wr(8'h00, 8'h22);
    rd(8'h00, 8'h22);
    pot_bus_master_i.read_two(dev, 8'h00, rd0, rd1, acks);
    `CHK(acks, 3'b111)
    `CHK({rd0, rd1}, 16'h2222)
    wrap_up();
  end
endmodule
